/* design/flash_host.sv */
// wishbone-controlled host sequencer for a byte-wide parallel nor flash
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
module flash_host
  import flash_host_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic                   flash_ce_n_o,
  output logic                   flash_oe_n_o,
  output logic                   flash_we_n_o,
  input  wire logic [7:0]        flash_dq_i,
  output logic [7:0]             flash_dq_o,
  output logic                   flash_dq_oe_o
);

  typedef enum logic [2:0] {
    st_idle = 3'b000, st_issue = 3'b001, st_wait = 3'b011, st_poll = 3'b010, st_pwait = 3'b110
  } state_type;

  // ----------------------------------------
  // registers and bus decode
  // ----------------------------------------
  state_type         state;
  op_type            op;
  logic [2:0]        step;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  logic [7:0]        prev_read;
  logic              first_poll;
  logic              fail;
  logic              refused;
  logic              erasing;
  logic              suspended;

  wire        bus_acc    = wb_cyc_i & wb_stb_i;
  wire        bus_wr     = bus_acc & wb_we_i & wb_ack_o;
  wire        busy       = (state != st_idle);
  wire        wr_cmd     = bus_wr && (wb_adr_i == REG_CMD) && wb_sel_i[0];
  wire        wr_addr    = bus_wr && (wb_adr_i == REG_ADDR);
  wire        wr_wdata   = bus_wr && (wb_adr_i == REG_WDATA) && wb_sel_i[0];
  wire        wr_status  = bus_wr && (wb_adr_i == REG_STATUS) && wb_sel_i[0];
  wire        cmd_go     = wr_cmd && !busy;
  wire        cmd_refuse = wr_cmd && busy;
  wire [31:0] byte_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] addr_merge = ({15'h0000, addr} & ~byte_mask) | (wb_dat_i & byte_mask);
  wire [4:0]  status_bits = {suspended, erasing, refused, fail, busy};

  logic [31:0] read_mux;
  always_comb begin
    case (wb_adr_i)
      REG_CMD:    read_mux = {28'h0000000, op};
      REG_ADDR:   read_mux = {15'h0000, addr};
      REG_WDATA:  read_mux = {24'h000000, wdata};
      REG_RDATA:  read_mux = {24'h000000, rdata};
      REG_STATUS: read_mux = {27'h0000000, status_bits};
      default:    read_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_acc & ~wb_ack_o;
      wb_dat_o <= read_mux;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr  <= '0;
      wdata <= '0;
    end else begin
      if (wr_addr) addr <= addr_merge[ADDR_W-1:0];
      if (wr_wdata) wdata <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------
  // pin cycle engine
  // ----------------------------------------
  step_type          cur;
  logic              cyc_done;
  logic [7:0]        cyc_rdata;
  wire               cyc_start = (state == st_issue) || (state == st_poll);
  wire               cyc_write = (state == st_issue) && !cur.is_read;
  wire [ADDR_W-1:0]  cyc_addr  = (state == st_poll) ? addr : cur.addr;

  assign cur = step_of(op, step, addr, wdata);

  flash_bus_cycle u_cycle (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .start_i       (cyc_start),
    .write_i       (cyc_write),
    .addr_i        (cyc_addr),
    .wdata_i       (cur.data),
    .done_o        (cyc_done),
    .rdata_o       (cyc_rdata),
    .flash_addr_o  (flash_addr_o),
    .flash_ce_n_o  (flash_ce_n_o),
    .flash_oe_n_o  (flash_oe_n_o),
    .flash_we_n_o  (flash_we_n_o),
    .flash_dq_i    (flash_dq_i),
    .flash_dq_o    (flash_dq_o),
    .flash_dq_oe_o (flash_dq_oe_o)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  wire toggle_stopped = !first_poll && (cyc_rdata[BIT_TOGGLE] == prev_read[BIT_TOGGLE]);
  wire limit_hit      = !first_poll && cyc_rdata[BIT_TIME_LIMIT];
  wire program_bad    = (op == OP_PROGRAM) && (cyc_rdata[BIT_POLL] != wdata[BIT_POLL]);
  wire poll_after     = (op == OP_PROGRAM) || (op == OP_POLL);
  wire set_fail       = (state == st_pwait) && cyc_done && !toggle_stopped && limit_hit;
  wire set_bad        = (state == st_pwait) && cyc_done && toggle_stopped && program_bad;
  wire erase_started  = (state == st_wait) && cyc_done && cur.last
                        && ((op == OP_CHIP_ERASE) || (op == OP_SECTOR_ERASE));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= st_idle;
      op         <= OP_READ;
      step       <= STEP_ZERO;
      rdata      <= '0;
      prev_read  <= '0;
      first_poll <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          if (cmd_go) begin
            op    <= op_type'(wb_dat_i[3:0]);
            step  <= STEP_ZERO;
            first_poll <= 1'b1;
            state <= (op_type'(wb_dat_i[3:0]) == OP_POLL) ? st_poll : st_issue;
          end
        end
        st_issue: state <= st_wait;
        st_wait: begin
          if (cyc_done) begin
            if (cur.is_read) rdata <= cyc_rdata;
            if (!cur.last) begin
              step  <= step + STEP_ONE;
              state <= st_issue;
            end else begin
              state <= poll_after ? st_poll : st_idle;
            end
          end
        end
        st_poll: state <= st_pwait;
        st_pwait: begin
          if (cyc_done) begin
            first_poll <= 1'b0;
            prev_read  <= cyc_rdata;
            rdata      <= cyc_rdata;
            if (toggle_stopped) begin
              state <= st_idle;
            end else if (limit_hit) begin
              // a timed-out device stays stuck until told to reset
              op    <= OP_RESET;
              step  <= STEP_ZERO;
              state <= st_issue;
            end else begin
              state <= st_poll;
            end
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // ----------------------------------------
  // status flags; hardware set wins over clear
  // ----------------------------------------
  wire op_finished = (state == st_wait) && cyc_done && cur.last;
  wire poll_ended  = (state == st_pwait) && cyc_done && toggle_stopped;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail      <= 1'b0;
      refused   <= 1'b0;
      erasing   <= 1'b0;
      suspended <= 1'b0;
    end else begin
      fail    <= set_fail || set_bad || (fail && !(wr_status && wb_dat_i[ST_FAIL]));
      refused <= cmd_refuse || (refused && !(wr_status && wb_dat_i[ST_REFUSED]));
      if (erase_started) erasing <= 1'b1;
      else if (poll_ended || (op_finished && (op == OP_RESET))) erasing <= 1'b0;
      // reads inside a suspended sector return status, so software tracks it here
      if (op_finished && (op == OP_SUSPEND)) suspended <= 1'b1;
      else if (op_finished && ((op == OP_RESUME) || (op == OP_RESET))) suspended <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [7:0] hist_1;
  logic [7:0] hist_0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hist_1 <= '0;
      hist_0 <= '0;
    end else if ($rose(flash_we_n_o)) begin
      hist_1 <= hist_0;
      hist_0 <= flash_dq_o;
    end
  end

  sequence s_reset_write;
    $rose(flash_we_n_o) && (flash_dq_o == CMD_RESET);
  endsequence
  sequence s_setup_write(logic [7:0] code);
    $rose(flash_we_n_o) && (flash_addr_o == UNLOCK_ADDR_1) && (flash_dq_o == code) && (hist_0 != code);
  endsequence

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held longer than one cycle");
  a_program_unlocked: assert property (s_setup_write(CMD_PROGRAM) |->
                                       (hist_0 == UNLOCK_DATA_2) && (hist_1 == UNLOCK_DATA_1))
    else $error("program setup without unlock pair");
  a_erase_unlocked: assert property (s_setup_write(CMD_ERASE_SET) |->
                                     (hist_0 == UNLOCK_DATA_2) && (hist_1 == UNLOCK_DATA_1))
    else $error("erase setup without unlock pair");
  a_timeout_reset: assert property ($rose(fail) && !$past(toggle_stopped) |-> ##[1:20] s_reset_write)
    else $error("no reset command after time limit");
  a_id_exit_reset: assert property ((state == st_wait) && cyc_done && cur.is_read && (op == OP_ID_READ)
                                    |-> ##[1:20] s_reset_write)
    else $error("autoselect left without reset");
  a_idle_pins: assert property (!busy && !$past(busy) |-> flash_ce_n_o && !flash_dq_oe_o)
    else $error("pins active while idle");

endmodule

/* design/flash_host_pkg.sv */
// constants, register map and command sequences for the parallel flash host controller
//
// Behaviour
// - issue reset after time limit flag or autoselect
// - high-voltage identification is for programmers
// - in-system identification by autoselect command sequence
// - write cycle: select, strobe low, gate high
// - two unlock writes precede program, erase and autoselect sequences
// - F0 resets; unlock plus 90 autoselects
// - program is unlock, A0, then data
// - erase is six writes, chip or sector
// - suspend B0, resume 30, any address
package flash_host_pkg;

  // ----------------------------------------
  // flash geometry and command bytes
  // ----------------------------------------
  localparam int          ADDR_W         = 17;
  localparam int          SEC_HI         = 16;
  localparam int          SEC_LO         = 12;
  localparam logic [11:0] SEC_OFFSET_ZERO = 12'h000;
  localparam logic [16:0] UNLOCK_ADDR_1  = 17'h00555;
  localparam logic [16:0] UNLOCK_ADDR_2  = 17'h002aa;
  localparam logic [7:0]  UNLOCK_DATA_1  = 8'haa;
  localparam logic [7:0]  UNLOCK_DATA_2  = 8'h55;
  localparam logic [7:0]  CMD_RESET      = 8'hf0;
  localparam logic [7:0]  CMD_AUTOSELECT = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM    = 8'ha0;
  localparam logic [7:0]  CMD_ERASE_SET  = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0]  CMD_SEC_ERASE  = 8'h30;
  localparam logic [7:0]  CMD_SUSPEND    = 8'hb0;
  localparam logic [7:0]  CMD_RESUME     = 8'h30;
  localparam int          BIT_POLL       = 7;
  localparam int          BIT_TOGGLE     = 6;
  localparam int          BIT_TIME_LIMIT = 5;

  // ----------------------------------------
  // pin timing at 10 MHz
  // ----------------------------------------
  localparam int         CLK_NS       = 100;
  localparam int         ACCESS_NS    = 70;
  localparam int         WE_PULSE_NS  = 35;
  localparam logic [3:0] ACCESS_CYC   = 4'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WE_PULSE_CYC = 4'((WE_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CNT_ONE      = 4'h1;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int ST_BUSY = 0;
  localparam int ST_FAIL = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_ERASING = 3;
  localparam int ST_SUSPENDED = 4;
  localparam logic [2:0] STEP_ZERO = 3'h0;
  localparam logic [2:0] STEP_ONE  = 3'h1;

  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET = 4'h1, OP_PROGRAM = 4'h2, OP_CHIP_ERASE = 4'h3,
    OP_SECTOR_ERASE = 4'h4, OP_SUSPEND = 4'h5, OP_RESUME = 4'h6, OP_ID_READ = 4'h7,
    OP_POLL = 4'h8
  } op_type;

  typedef struct packed {
    logic              is_read;
    logic              last;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } step_type;

  // one bus cycle of a command sequence
  function automatic step_type step_of(input op_type op, input logic [2:0] idx,
                                       input logic [ADDR_W-1:0] a, input logic [7:0] d);
    step_type s;
    s = '{is_read: 1'b0, last: 1'b1, addr: a, data: CMD_RESET};
    if (op == OP_PROGRAM || op == OP_CHIP_ERASE || op == OP_SECTOR_ERASE || op == OP_ID_READ) begin
      s.last = 1'b0;
      case (idx)
        3'h0, 3'h3: begin
          s.addr = UNLOCK_ADDR_1;
          s.data = UNLOCK_DATA_1;
        end
        3'h1, 3'h4: begin
          s.addr = UNLOCK_ADDR_2;
          s.data = UNLOCK_DATA_2;
        end
        default: begin
          s.addr = UNLOCK_ADDR_1;
          s.data = CMD_ERASE_SET;
        end
      endcase
    end
    case (op)
      OP_READ: s.is_read = 1'b1;
      OP_SUSPEND: s.data = CMD_SUSPEND;
      OP_RESUME: s.data = CMD_RESUME;
      OP_PROGRAM: begin
        if (idx == 3'h2) s.data = CMD_PROGRAM;
        if (idx == 3'h3) begin
          s.addr = a;
          s.data = d;
          s.last = 1'b1;
        end
      end
      OP_CHIP_ERASE: begin
        if (idx == 3'h5) begin
          s.addr = UNLOCK_ADDR_1;
          s.data = CMD_CHIP_ERASE;
          s.last = 1'b1;
        end
      end
      OP_SECTOR_ERASE: begin
        if (idx == 3'h5) begin
          s.addr = {a[SEC_HI:SEC_LO], SEC_OFFSET_ZERO};
          s.data = CMD_SEC_ERASE;
          s.last = 1'b1;
        end
      end
      OP_ID_READ: begin
        if (idx == 3'h2) s.data = CMD_AUTOSELECT;
        if (idx == 3'h3) begin
          s.addr = a;
          s.is_read = 1'b1;
        end
        if (idx == 3'h4) begin
          s.addr = a;
          s.data = CMD_RESET;
          s.last = 1'b1;
        end
      end
      default: s.last = 1'b1;
    endcase
    return s;
  endfunction

endpackage

/* design/flash_bus_cycle.sv */
// one read or write cycle on the flash pins
`timescale 1ns/10ps
module flash_bus_cycle
  import flash_host_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              start_i,
  input  wire logic              write_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  output logic                   done_o,
  output logic [7:0]             rdata_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic                   flash_ce_n_o,
  output logic                   flash_oe_n_o,
  output logic                   flash_we_n_o,
  input  wire logic [7:0]        flash_dq_i,
  output logic [7:0]             flash_dq_o,
  output logic                   flash_dq_oe_o
);

  typedef enum logic [1:0] {ph_idle = 2'b00, ph_setup = 2'b01, ph_strobe = 2'b11, ph_hold = 2'b10} phase_type;

  phase_type  phase;
  logic [3:0] cnt;
  logic       is_write;
  wire        strobe_end = (phase == ph_strobe) && (cnt == CNT_ONE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase         <= ph_idle;
      cnt           <= '0;
      is_write      <= 1'b0;
      done_o        <= 1'b0;
      rdata_o       <= '0;
      flash_addr_o  <= '0;
      flash_ce_n_o  <= 1'b1;
      flash_oe_n_o  <= 1'b1;
      flash_we_n_o  <= 1'b1;
      flash_dq_o    <= '0;
      flash_dq_oe_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (phase)
        ph_idle: begin
          if (start_i) begin
            // address settles with the chip select, before any strobe falls
            flash_addr_o  <= addr_i;
            flash_dq_o    <= wdata_i;
            is_write      <= write_i;
            flash_ce_n_o  <= 1'b0;
            flash_dq_oe_o <= write_i;
            phase         <= ph_setup;
          end
        end
        ph_setup: begin
          // gate stays high on writes, so the three controls are never all low
          flash_we_n_o <= ~is_write;
          flash_oe_n_o <= is_write;
          cnt          <= is_write ? WE_PULSE_CYC : ACCESS_CYC;
          phase        <= ph_strobe;
        end
        ph_strobe: begin
          cnt <= cnt - CNT_ONE;
          if (strobe_end) begin
            // data still driven across the strobe's rising edge
            flash_we_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            if (!is_write) rdata_o <= flash_dq_i;
            phase <= ph_hold;
          end
        end
        ph_hold: begin
          flash_ce_n_o  <= 1'b1;
          flash_dq_oe_o <= 1'b0;
          done_o        <= 1'b1;
          phase         <= ph_idle;
        end
        default: phase <= ph_idle;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_no_three_low: assert property (!(!flash_ce_n_o && !flash_oe_n_o && !flash_we_n_o))
    else $error("chip select, gate and strobe all low");
  a_dq_gate_high: assert property (flash_dq_oe_o |-> flash_oe_n_o)
    else $error("host drives data while device output gate low");
  a_we_pulse_width: assert property ($fell(flash_we_n_o) |-> !flash_ce_n_o ##1 $rose(flash_we_n_o))
    else $error("write strobe pulse not one full cycle");
  a_data_at_rise: assert property ($rose(flash_we_n_o) |-> flash_dq_oe_o && !flash_ce_n_o
                                   && $stable(flash_dq_o))
    else $error("data not held across strobe rise");
  a_addr_stable: assert property (!flash_we_n_o || !flash_oe_n_o |-> $stable(flash_addr_o))
    else $error("address moved during strobe");

endmodule

/* tb/flash_model.sv */
// behavioural byte-wide nor flash answering the host pins
`timescale 1ns/10ps
module flash_model #(
  parameter int         PROG_STEPS  = 30,
  parameter int         ERASE_STEPS = 300,
  parameter logic [7:0] MAN_ID      = 8'h3c, // arbitrary value
  parameter logic [7:0] DEV_ID      = 8'h4e, // arbitrary value
  parameter logic [4:0] PROT_SEC    = 5'h1f
) (
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [16:0] addr_i,
  input  wire logic [7:0]  dq_i,
  output logic [7:0]       dq_o,
  output logic             dq_oe_o
);
  logic [7:0]  mem [131072];
  logic [16:0] la;
  logic [7:0]  program_byte;
  logic [4:0]  es;
  // power-up starts in array read with the decoder cleared and nothing pending
  logic        asel = 0, esus = 0, tog = 0;
  int          st = 0, left = 0, ev = 0, kind = 0;
  initial for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
  assign dq_oe_o = !ce_n_i && !oe_n_i;
  always @(negedge we_n_i or negedge ce_n_i) if (!ce_n_i && !we_n_i) la = addr_i;
  always @(posedge we_n_i or posedge ce_n_i) if (oe_n_i && (we_n_i ^ ce_n_i)) wr(la, dq_i);
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    ev++;
    if (esus) begin
      if (d == 8'h30) esus = 0;
      return;
    end
    if (left > 0) begin
      if (kind == 2 && d == 8'hb0) esus = 1;
      return;
    end
    case (st)
      0: begin
        if (d == 8'hf0) asel = 0;
        st = (a == 17'h555 && d == 8'haa) ? 1 : 0;
      end
      1, 5: st = (a == 17'h2aa && d == 8'h55) ? st + 1 : 0;
      4: st = (a == 17'h555 && d == 8'haa) ? 5 : 0;
      2: begin
        asel = asel | (a == 17'h555 && d == 8'h90);
        st = a != 17'h555 ? 0 : d == 8'ha0 ? 3 : d == 8'h80 ? 4 : 0;
      end
      3: begin
        st = 0;
        if (a[16:12] != PROT_SEC) begin
          program_byte = d;
          mem[a] = mem[a] & d;
          kind = 0;
          left = PROG_STEPS;
        end
      end
      default: begin
        st = 0;
        if (a == 17'h555 && d == 8'h10) begin
          kind = 1;
          left = ERASE_STEPS;
          for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
        end else if (d == 8'h30 && a[16:12] != PROT_SEC) begin
          kind = 2;
          es = a[16:12];
          left = ERASE_STEPS;
          for (int i = 0; i < 4096; i++) mem[{es, 12'(i)}] = 8'hff;
        end
      end
    endcase
  endtask
  // embedded timer; a suspended erase holds its count
  always begin
    #100;
    if (left > 0 && !esus) left--;
  end
  always @(negedge oe_n_i) if (!ce_n_i && left > 0) tog = ~tog;
  always @(addr_i, tog, left, esus, asel, ev) begin
    if (asel)
      dq_o = addr_i[1:0] == 2'h0 ? MAN_ID : addr_i[1:0] == 2'h1 ? DEV_ID : {7'h0, addr_i[16:12] == PROT_SEC};
    else if (left > 0 && !(esus && addr_i[16:12] != es))
      dq_o = {kind == 0 ? ~program_byte[7] : esus, tog, 6'h0};
    else
      dq_o = mem[addr_i];
  end
endmodule

/* tb/tb.sv */
// self-checking bench: wishbone software driving the host against the flash model
`timescale 1ns/10ps
module tb;
  import flash_host_pkg::*;
  localparam logic [7:0] MID = 8'h3c; // arbitrary value
  localparam logic [7:0] DID = 8'h4e; // arbitrary value
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00, pat = 8'h00, d1, d2;
  logic [31:0] wdat = 32'h0, q, seed = 32'haecded2a;
  logic [16:0] a1, ida [4] = '{17'h0, 17'h1, 17'h1f002, 17'h00002};
  logic [7:0]  ide [4] = '{MID, DID, 8'h01, 8'h00};
  wire  [31:0] rdat;
  wire         ack, ce_n, oe_n, we_n, h_oe, m_oe;
  wire  [16:0] fa;
  wire  [7:0]  h_dq, m_dq;
  wire  [7:0]  dq = h_oe ? h_dq : m_oe ? m_dq : pat;
  int          error_cnt = 0, checks_done = 0;
  flash_host u_flash_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .flash_addr_o(fa),
    .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_dq_i(dq), .flash_dq_o(h_dq),
    .flash_dq_oe_o(h_oe));
  flash_model #(.MAN_ID(MID), .DEV_ID(DID)) u_flash_model (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .addr_i(fa), .dq_i(dq), .dq_o(m_dq), .dq_oe_o(m_oe));
  initial forever #50 clk_i = ~clk_i;
  // released bus shows a changing pattern, never a held value
  always @(posedge clk_i) pat <= pat + 8'h35;
  always @(posedge clk_i) if (!rst_i) chk("pin_ctl", 0, 32'((h_oe | !we_n) & !oe_n));
  function automatic logic [31:0] rnd(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // a cell can only lose ones when programmed
  function automatic logic [31:0] prog_exp(input logic [7:0] o, input logic [7:0] d);
    return {24'h0, o & d};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("wb_ack", 1, 0);
      test_done;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic op(input op_type o);
    int n;
    n = 0;
    wb(1'b1, REG_CMD, {28'h0, o});
    do begin
      wb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) begin
      chk("busy_wait", 0, 1);
      test_done;
    end
  endtask
  task automatic rd(input logic [16:0] a);
    wb(1'b1, REG_ADDR, {15'h0, a});
    op(OP_READ);
    wb(1'b0, REG_RDATA, 32'h0);
  endtask
  task automatic prog(input logic [16:0] a, input logic [7:0] d);
    wb(1'b1, REG_ADDR, {15'h0, a});
    wb(1'b1, REG_WDATA, {24'h0, d});
    op(OP_PROGRAM);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status_rst", 0, q);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 0, q);
    rd(17'h00123);
    chk("array_rst", 32'hff, q);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      seed = rnd(seed);
      // random targets stay in sector 1, clear of the fixed-address scenarios
      a1 = {5'h01, seed[11:0]};
      d1 = seed[23:16];
      d2 = seed[31:24];
      prog(a1, d1);
      chk("prog_fail", 0, q[ST_FAIL]);
      rd(a1);
      chk("prog_data", {24'h0, d1}, q);
      prog(a1, d2);
      chk("reprog_fail", 32'(~d1[7] & d2[7]), q[ST_FAIL]);
      wb(1'b1, REG_STATUS, 32'h2);
      rd(a1);
      chk("reprog", prog_exp(d1, d2), q);
    end
    $display("test program done");
    prog(17'h1f010, 8'h00);
    chk("prot_fail", 1, q[ST_FAIL]);
    wb(1'b1, REG_STATUS, 32'h2);
    rd(17'h1f010);
    chk("prot_data", 32'hff, q);
    wb(1'b1, REG_ADDR, 32'h00200);
    wb(1'b1, REG_CMD, {28'h0, OP_PROGRAM});
    wb(1'b1, REG_CMD, {28'h0, OP_RESET});
    op(OP_RESET);
    chk("refused", 1, q[ST_REFUSED]);
    wb(1'b1, REG_STATUS, 32'h4);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("refused_clr", 0, q);
    op(OP_RESET);
    chk("reset_idle", 0, q);
    $display("test refuse done");
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, REG_ADDR, {15'h0, ida[i]});
      op(OP_ID_READ);
      wb(1'b0, REG_RDATA, 32'h0);
      chk("id_code", {24'h0, ide[i]}, q);
    end
    $display("test id done");
    prog(17'h03010, 8'h5a);
    prog(17'h04020, 8'ha5);
    wb(1'b1, REG_ADDR, 32'h03010);
    op(OP_SECTOR_ERASE);
    chk("erasing", 1, q[ST_ERASING]);
    op(OP_SUSPEND);
    chk("suspended", 1, q[ST_SUSPENDED]);
    rd(17'h04020);
    chk("susp_other", 32'ha5, q);
    rd(17'h03010);
    chk("susp_status", 1, q[7]);
    op(OP_RESUME);
    op(OP_POLL);
    chk("erase_end", 0, q[ST_ERASING]);
    rd(17'h03010);
    chk("sec_erased", 32'hff, q);
    rd(17'h04020);
    chk("sec_kept", 32'ha5, q);
    op(OP_CHIP_ERASE);
    op(OP_POLL);
    rd(17'h04020);
    chk("chip_erased", 32'hff, q);
    $display("test erase done");
    test_done;
  end
endmodule
